/* hw/uiec_event_latch.sv */
// Sticky pending-event latch, set wins over a clear in the same cycle
`timescale 1ns/1ps
module uiec_event_latch
  import uiec_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  uiec_evt_if.latch  evt
);

  uiec_latch_type st;
  uiec_latch_type next_st;

  // Clear first, then set, so an event in the clearing cycle survives
  always_comb begin
    next_st         = st;
    next_st.pending = (st.pending & ~evt.clear_bits) | evt.event_pulse;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign evt.pending = st.pending;

endmodule // uiec_event_latch

/* hw/uiec_evt_if.sv */
// Interface between the register slave and the pending-event latch
`timescale 1ns/1ps
interface uiec_evt_if #(
  parameter int N = 25
);
  logic [N-1:0] event_pulse;  // One-cycle event strobes
  logic [N-1:0] clear_bits;   // One-cycle clear from a status read
  logic [N-1:0] pending;      // Sticky pending bits

  modport ctrl  (output event_pulse, output clear_bits, input pending);
  modport latch (input event_pulse, input clear_bits, output pending);
endinterface

/* hw/uiec_irq_ctrl.sv */
// AHB-Lite slave holding the USB interrupt enables and the interrupt output
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module uiec_irq_ctrl
  import uiec_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic [NUM_EVENTS-1:0] event_pulse,
  output logic [NUM_EVENTS-1:0]      irq_enable,
  output logic                       irq
);

  // ************************************************************
  // State and the carrier to the pending latch
  // ************************************************************
  uiec_state_type        st;
  uiec_state_type        next_st;
  uiec_evt_if #(.N(NUM_EVENTS)) evt ();

  logic                  accept;
  logic [NUM_EVENTS-1:0] wbits;
  logic [NUM_EVENTS-1:0] clr_vec;
  logic [NUM_EVENTS-1:0] set_vec;
  logic                  load_read;

  // Sticky pending bits live in their own module
  uiec_event_latch u_latch (
    .clock (clock),
    .rst_n (rst_n),
    .evt   (evt)
  );

  // ************************************************************
  // Bus handshake
  // ************************************************************

  // Address phase is taken only while the bus is ready
  assign accept    = hsel && htrans[1] && hready;
  // Reads take one wait state so the returned word is a flip-flop
  assign load_read = st.rd_act && !st.rd_done;
  assign hreadyout = !load_read;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = st.rdata;
  assign irq       = st.irq;
  assign irq_enable = st.enable;

  // Partial-width writes are dropped at the address phase rather than merged
  assign wbits     = hwdata[NUM_EVENTS-1:0];

  // ************************************************************
  // Field-wise decode of a clear-register write
  // ************************************************************

  // Only ones disable; zero bits leave the enable alone [R14]
  always_comb begin
    clr_vec = '0;
    if (st.wr_act && (st.addr[ADDR_W-1:2] == OFF_ENABLE_CLEAR[ADDR_W-1:2])) begin
      clr_vec[BIT_BUS_RESET]                  = wbits[BIT_BUS_RESET];   // [R01]
      clr_vec[BIT_STARTED]                    = wbits[BIT_STARTED];     // [R02]
      clr_vec[LSB_IN_END +: NUM_ENDPOINTS]    =
        wbits[LSB_IN_END +: NUM_ENDPOINTS];                             // [R03]
      clr_vec[BIT_CTRL_DONE]                  = wbits[BIT_CTRL_DONE];   // [R04]
      clr_vec[BIT_ISO_IN_END]                 = wbits[BIT_ISO_IN_END];  // [R05]
      clr_vec[LSB_OUT_END +: NUM_ENDPOINTS]   =
        wbits[LSB_OUT_END +: NUM_ENDPOINTS];                            // [R06]
      clr_vec[BIT_ISO_OUT_END]                = wbits[BIT_ISO_OUT_END]; // [R07]
      clr_vec[BIT_SOF]                        = wbits[BIT_SOF];         // [R08]
      clr_vec[BIT_BUS_COND]                   = wbits[BIT_BUS_COND];    // [R09]
      clr_vec[BIT_CTRL_SETUP]                 = wbits[BIT_CTRL_SETUP];  // [R10]
      clr_vec[BIT_ACKED_DATA]                 = wbits[BIT_ACKED_DATA];  // [R11]
    end
  end

  // Set-register write acts on the same enable store [R12]
  always_comb begin
    set_vec = '0;
    if (st.wr_act && (st.addr[ADDR_W-1:2] == OFF_ENABLE_SET[ADDR_W-1:2])) begin
      set_vec = wbits;
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    next_st = st;
    evt.event_pulse = event_pulse;
    evt.clear_bits  = '0;

    // Write data phase: hwdata is valid now, commit at this edge
    if (st.wr_act) begin
      next_st.wr_act = 1'b0;
      next_st.enable = (st.enable & ~clr_vec) | set_vec;      // [R12] [R14]
    end

    // Read data phase, wait cycle: load the word from live state
    if (load_read) begin
      next_st.rd_done = 1'b1;
      unique case (st.addr[ADDR_W-1:2])
        OFF_ENABLE_SET[ADDR_W-1:2],
        OFF_ENABLE_CLEAR[ADDR_W-1:2]: begin
          next_st.rdata = {{(32-NUM_EVENTS){1'b0}}, st.enable};  // [R13]
        end
        OFF_PENDING[ADDR_W-1:2]: begin
          next_st.rdata  = {{(32-NUM_EVENTS){1'b0}}, evt.pending};
          // Reading the status word clears what it returned
          evt.clear_bits = evt.pending;
        end
        default: begin
          next_st.rdata = READ_ZERO;
        end
      endcase
    end else if (st.rd_act) begin
      // Data taken at this edge
      next_st.rd_act  = 1'b0;
      next_st.rd_done = 1'b0;
    end

    // New address phase overrides the idle values above
    if (accept) begin
      next_st.addr    = haddr[ADDR_W-1:0];
      next_st.wr_act  = hwrite && (hsize == HSIZE_WORD);
      next_st.rd_act  = !hwrite;
      next_st.rd_done = 1'b0;
    end

    // Level interrupt from unmasked pending events
    next_st.irq = |(evt.pending & st.enable);
  end

  // ************************************************************
  // State register
  // ************************************************************

  // All enables reset to disabled [R13]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.enable <= ENABLE_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule // uiec_irq_ctrl

/* hw/uiec_pkg.sv */
// Constants, register map and state types of the USB interrupt-enable block
// Function
// R01 - Writing one to bit 0 at 0x308 disables the bus reset interrupt.
// R02 - Writing one to bit 1 disables the transfer-started interrupt.
// R03 - Bits 2 to 9 disable IN endpoint 0..7 transfer-end interrupts.
// R04 - Writing one to bit 10 disables the control data-done interrupt.
// R05 - Writing one to bit 11 disables the isochronous IN end interrupt.
// R06 - Bits 12 to 19 disable OUT endpoint 0..7 transfer-end interrupts.
// R07 - Writing one to bit 20 disables the isochronous OUT end interrupt.
// R08 - Writing one to bit 21 disables the start-of-frame interrupt.
// R09 - Writing one to bit 22 disables the general bus condition interrupt.
// R10 - Writing one to bit 23 disables the control setup interrupt.
// R11 - Writing one to bit 24 disables the acknowledged data interrupt.
// R12 - Clear register and set register at 0x304 share one enable store.
// R13 - Reads return the 25-bit enable mask; reset zero; bits 31..25 zero.
// R14 - Writing zero to a bit leaves that enable unchanged.
package uiec_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          ADDR_W           = 12;
  localparam int          NUM_EVENTS       = 25;
  localparam logic [11:0] OFF_PENDING      = 12'h0300;
  localparam logic [11:0] OFF_ENABLE_SET   = 12'h0304;
  localparam logic [11:0] OFF_ENABLE_CLEAR = 12'h0308;
  localparam logic [24:0] ENABLE_RESET     = 25'h000_0000;
  localparam logic [31:0] READ_ZERO        = 32'h0000_0000;

  // ************************************************************
  // Field positions inside the enable and pending words
  // ************************************************************
  localparam int BIT_BUS_RESET    = 0;
  localparam int BIT_STARTED      = 1;
  localparam int LSB_IN_END       = 2;
  localparam int BIT_CTRL_DONE    = 10;
  localparam int BIT_ISO_IN_END   = 11;
  localparam int LSB_OUT_END      = 12;
  localparam int BIT_ISO_OUT_END  = 20;
  localparam int BIT_SOF          = 21;
  localparam int BIT_BUS_COND     = 22;
  localparam int BIT_CTRL_SETUP   = 23;
  localparam int BIT_ACKED_DATA   = 24;
  localparam int NUM_ENDPOINTS    = 8;

  // ************************************************************
  // AHB-Lite encodings
  // ************************************************************
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic       HRESP_OKAY = 1'b0;

  // Register state of the top module
  typedef struct packed {
    logic                  wr_act;   // Write data phase pending
    logic                  rd_act;   // Read data phase pending
    logic                  rd_done;  // Read data loaded, hready released
    logic [ADDR_W-1:0]     addr;     // Latched address phase
    logic [NUM_EVENTS-1:0] enable;   // Shared enable store
    logic [31:0]           rdata;    // Read data register
    logic                  irq;      // Interrupt output register
  } uiec_state_type;

  // Register state of the pending latch
  typedef struct packed {
    logic [NUM_EVENTS-1:0] pending;
  } uiec_latch_type;

endpackage

/* sim/tb_usb_device_irq_enable_clear.sv */
// Self-checking bench for the USB interrupt-enable register slave
`timescale 1ns/1ps
module tb_usb_device_irq_enable_clear
  import uiec_pkg::*;
;
  logic        clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, s;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rq, hrd_q, d;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = HSIZE_WORD, sz;
  logic [24:0] ev = '0, irq_enable, m;
  logic        hreadyout, hresp, irq, rdy;
  integer      seed = 15, n_mismatch = 0, checks = 0, i;

  always #2.5 clock = ~clock;
  // Values seen at the falling edge are those the next rising edge samples
  always @(negedge clock) begin
    rdy = hreadyout;
    hrd_q = hrdata;
  end

  uiec_irq_ctrl uut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .event_pulse(ev),
    .irq_enable(irq_enable), .irq(irq));

  // ************************************************************
  // Bus master, compare and expectation helpers
  // ************************************************************
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single transfer; no wait count assumed, the watchdog ends a hang
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [2:0] z);
    hsel <= 1'b1; haddr <= {20'h0_0000, a}; htrans <= 2'h2; hwrite <= w; hsize <= z;
    do @(posedge clock); while (rdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clock); while (rdy !== 1'b1);
    rq = hrd_q;
    chk("hresp", {31'h0000_0000, HRESP_OKAY}, {31'h0000_0000, hresp});
  endtask

  task irq_chk(input logic e);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
    @(posedge clock);
  endtask

  task pulse(input int b);
    ev <= 25'h1 << b;
    @(posedge clock);
    ev <= '0;
  endtask

  function logic [24:0] upd(input logic [24:0] o, input logic [31:0] v, input logic st);
    return st ? (o | v[24:0]) : (o & ~v[24:0]);
  endfunction

  task report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, OFF_ENABLE_CLEAR, 32'h0, HSIZE_WORD);
    chk("reset mask", 32'h0000_0000, rq);
    // Enable everything, then knock out one event at a time
    bus(1'b1, OFF_ENABLE_SET, 32'hFFFF_FFFF, HSIZE_WORD);
    m = '1;
    for (i = 0; i < NUM_EVENTS; i++) begin
      bus(1'b1, OFF_ENABLE_CLEAR, 32'h1 << i, HSIZE_WORD);
      m = upd(m, 32'h1 << i, 1'b0);
      bus(1'b0, OFF_ENABLE_CLEAR, 32'h0, HSIZE_WORD);
      chk("bit clear", {7'h00, m}, rq);
      chk("mask port", {7'h00, m}, {7'h00, irq_enable});
    end
    // Random set and clear words, some of them sub-word and so ignored
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      s = d[31];
      sz = (i % 8 == 7) ? 3'h0 : HSIZE_WORD;
      bus(1'b1, s ? OFF_ENABLE_SET : OFF_ENABLE_CLEAR, d, sz);
      if (sz == HSIZE_WORD) m = upd(m, d, s);
      bus(1'b0, s ? OFF_ENABLE_CLEAR : OFF_ENABLE_SET, 32'h0, HSIZE_WORD);
      chk("shared mask", {7'h00, m}, rq);
    end
    bus(1'b0, 12'h010, 32'h0, HSIZE_WORD);
    chk("unmapped", 32'h0000_0000, rq);
    // Interrupt raised, masked, and the sticky status cleared by reading it
    bus(1'b1, OFF_ENABLE_CLEAR, 32'hFFFF_FFFF, HSIZE_WORD);
    bus(1'b1, OFF_ENABLE_SET, 32'h1 << BIT_SOF, HSIZE_WORD);
    pulse(BIT_SOF);
    irq_chk(1'b1);
    bus(1'b1, OFF_ENABLE_CLEAR, 32'h1 << BIT_SOF, HSIZE_WORD);
    irq_chk(1'b0);
    bus(1'b1, OFF_ENABLE_SET, 32'h1 << BIT_SOF, HSIZE_WORD);
    pulse(BIT_BUS_RESET);
    irq_chk(1'b1);
    bus(1'b0, OFF_PENDING, 32'h0, HSIZE_WORD);
    chk("pending", 32'h1 << BIT_SOF | 32'h1, rq);
    irq_chk(1'b0);
    // An event landing on the clearing edge of a status read must survive it
    pulse(BIT_SOF);
    fork
      bus(1'b0, OFF_PENDING, 32'h0, HSIZE_WORD);
      begin
        @(posedge clock);
        pulse(BIT_SOF);
      end
    join
    chk("pending first", 32'h1 << BIT_SOF, rq);
    bus(1'b0, OFF_PENDING, 32'h0, HSIZE_WORD);
    chk("pending kept", 32'h1 << BIT_SOF, rq);
    // Reset in mid-run drops every enable back to disabled
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, OFF_ENABLE_CLEAR, 32'h0, HSIZE_WORD);
    chk("mask after reset", 32'h0000_0000, rq);
    chk("irq after reset", 32'h0000_0000, {31'h0000_0000, irq});
    report_and_stop;
  end
endmodule // tb_usb_device_irq_enable_clear

/* sim/uiec_monitor.sv */
// Bus and interrupt assertions bound to the USB interrupt-enable slave
`timescale 1ns/1ps
module uiec_monitor
  import uiec_pkg::*;
(
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [2:0]            hsize,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic [31:0]           hrdata,
  input wire logic [NUM_EVENTS-1:0] event_pulse,
  input wire logic [NUM_EVENTS-1:0] irq_enable,
  input wire logic                  irq
);
  // ************************************************************
  // Data-phase trackers for the two enable registers
  // ************************************************************
  logic wc;
  logic ws;
  wire  take  = hsel && htrans[1] && hready;
  wire  wword = take && hwrite && (hsize == HSIZE_WORD);
  wire  rd_en = take && !hwrite && (haddr[11:2] == OFF_ENABLE_SET[11:2]
                || haddr[11:2] == OFF_ENABLE_CLEAR[11:2]);

  // Mark the cycle after a word write is taken, when hwdata stands
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wc <= 1'b0;
      ws <= 1'b0;
    end else begin
      wc <= wword && (haddr[11:2] == OFF_ENABLE_CLEAR[11:2]);
      ws <= wword && (haddr[11:2] == OFF_ENABLE_SET[11:2]);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  clr_write_a: assert property (
    wc |=> irq_enable == ($past(irq_enable) & ~$past(hwdata[24:0])))
    else $error("clear write gave wrong enable mask");
  set_write_a: assert property (
    ws |=> irq_enable == ($past(irq_enable) | $past(hwdata[24:0])))
    else $error("set write gave wrong enable mask");
  mask_hold_a: assert property (!(wc || ws) |=> $stable(irq_enable))
    else $error("enable mask moved without a write");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  read_data_a: assert property (rd_en |-> ##2 hrdata == {7'h00, $past(irq_enable)})
    else $error("enable read data wrong");
  irq_cause_a: assert property (irq |-> $past(|irq_enable))
    else $error("irq high with no enable");
  irq_masked_a: assert property (irq_enable == '0 |=> !irq)
    else $error("irq high while all masked");
  irq_raise_a: assert property ((|(event_pulse & irq_enable)) ##1 $stable(irq_enable) |=> irq)
    else $error("enabled event did not raise irq");
endmodule // uiec_monitor

bind uiec_irq_ctrl uiec_monitor u_mon (.clock(clock), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .event_pulse(event_pulse), .irq_enable(irq_enable), .irq(irq));
